// *** sim/pin_ctrl.sv ***
// pin-side model: system logic driving mode, clocks and data
`timescale 1ns/100ps
module pin_ctrl (
   input  wire logic  sys_clk,
   output logic       mode_sel,
   output logic       shift_clk,
   output logic       load_clk,
   output logic       serial_in,
   output logic [3:0] par_in
);
   // clocks idle high so release of reset makes no edge
   initial begin
      mode_sel = 1'b0;
      shift_clk = 1'b1;
      load_clk = 1'b1;
      serial_in = 1'b0;
      par_in = 4'h0;
   end
   // pins only move at falling sys_clk edges
   task automatic gap(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : gap
   // one pulse: mode and data settle, chosen clocks fall, then rise
   task automatic pulse(input logic md, input logic ld, input logic sh, input logic ser, input logic [3:0] par);
      mode_sel = md;
      serial_in = ser;
      par_in = par;
      gap(3);
      load_clk = ~ld;
      shift_clk = ~sh;
      gap(4);
      // the fall is through the synchroniser, so data lines may wander with the rise
      load_clk = 1'b1;
      shift_clk = 1'b1;
      serial_in = ~ser;
      par_in = ~par;
      gap(3);
   endtask : pulse
endmodule : pin_ctrl

// *** sim/tb_top.sv ***
// self-checking bench for the four-stage shift register
`timescale 1ns/100ps
module tb_top;
   import shift4_pkg::*;
   logic sys_clk, rst_n, snap_ready, stall, mode_sel, shift_clk, load_clk, serial_in;
   logic [3:0] par_in, snap_data, exp_q;
   logic st1, st2, st3, st4, snap_valid, snap_room, snap_drop, rdy;
   logic [3:0] exp_snap[$];
   int mismatches, n_tests, drops, seed, i;

   pin_ctrl i_drv (.sys_clk(sys_clk), .mode_sel(mode_sel), .shift_clk(shift_clk), .load_clk(load_clk),
      .serial_in(serial_in), .par_in(par_in));
   shift4_right_left i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_sel(mode_sel), .shift_clk(shift_clk),
      .load_clk(load_clk), .serial_in(serial_in), .par_in(par_in), .stage_one_out(st1),
      .stage_two_out(st2), .stage_three_out(st3), .stage_four_out(st4), .snap_valid(snap_valid),
      .snap_data(snap_data), .snap_ready(snap_ready), .snap_room(snap_room), .snap_drop(snap_drop));

   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check4(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check4

   // reference: only the clock the mode selects does anything
   function automatic logic [3:0] next_q(input logic [3:0] q, input logic md, input logic ld, input logic sh,
      input logic ser, input logic [3:0] par);
      if (md && ld) return par;
      if (!md && sh) return {q[2:0], ser};
      return q;
   endfunction : next_q

   task automatic op(input logic md, input logic ld, input logic sh, input logic ser, input logic [3:0] par);
      exp_q = next_q(exp_q, md, ld, sh, ser, par);
      if ((md && ld) || (!md && sh)) exp_snap.push_back(exp_q);
      i_drv.pulse(md, ld, sh, ser, par);
      check4("stages", exp_q, {st4, st3, st2, st1});
   endtask : op

   task automatic drain();
      int n;
      n = 0;
      while ((exp_snap.size() != 0 || snap_valid !== 1'b0) && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 300) begin
         mismatches++;
         print_verdict();
      end
   endtask : drain

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // consumer stalls at random; handshake judged with the ready value the next rising edge sees
   always @(negedge sys_clk) begin
      rdy = stall ? 1'b0 : 1'($random(seed));
      snap_ready <= rdy;
      if (rst_n && snap_valid === 1'b1 && rdy === 1'b1) begin
         if (exp_snap.size() == 0) check4("snap_extra", 4'h0, 4'hf);
         else check4("snap_data", exp_snap.pop_front(), snap_data);
      end
      if (rst_n && snap_drop === 1'b1) begin
         drops++;
         void'(exp_snap.pop_back());
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      stall = 1'b0;
      snap_ready = 1'b0;
      exp_q = 4'h0;
      seed = 32'h23db_6e35;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      i_drv.gap(3);
      // contents are only trusted after a first load
      op(1'b1, 1'b1, 1'b0, 1'b0, 4'ha);
      op(1'b1, 1'b1, 1'b1, 1'b1, 4'h5);
      op(1'b0, 1'b0, 1'b0, 1'b0, 4'hf);
      op(1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
      for (i = 0; i < 4; i++) op(1'b0, 1'b1, 1'b1, i[0], 4'h3);
      op(1'b1, 1'b0, 1'b0, 1'b1, 4'h0);
      // left shift through the outside wiring
      for (i = 0; i < 6; i++) op(1'b1, 1'b1, 1'b0, 1'b0, {i[1], st4, st3, st2});
      for (i = 0; i < 40; i++) op(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
         1'($random(seed)), 4'($random(seed)));
      drain();
      // fill the snapshot buffer until it refuses, then drain it
      stall = 1'b1;
      drops = 0;
      for (i = 0; i < 36; i++) op(1'b1, 1'b1, 1'b0, 1'b0, 4'(i));
      check4("drops", 4'h3, 4'(drops));
      check4("room", 4'h0, {3'h0, snap_room});
      stall = 1'b0;
      drain();
      i_drv.gap(3);
      check4("room", 4'h1, {3'h0, snap_room});
      print_verdict();
   end
endmodule : tb_top

// *** verilog/shift4_pkg.sv ***
// constants for the four-stage right/left shift register
package shift4_pkg;
   // pin vector layout after the input synchroniser
   localparam int PIN_W        = 8;
   localparam int PAR_LSB      = 0;   // parallel inputs one..four at bits 3:0
   localparam int SER_BIT      = 4;
   localparam int LOAD_CLK_BIT = 5;
   localparam int SHIFT_CLK_BIT = 6;
   localparam int MODE_BIT     = 7;
   // stage register
   localparam int STAGES       = 4;
   localparam logic [3:0] STAGE_RST = 4'h0;
   localparam logic [7:0] PIN_RST   = 8'h00;
   // snapshot buffer
   localparam int SNAP_DEPTH   = 32;
   // set to four, but a pin edge reaches the stages in three cycles: two sync stages plus stage flop, edge detect is combinational
   localparam int PIN_TO_STAGE = 4;
endpackage : shift4_pkg

// *** verilog/shift4_right_left.sv ***
// four-stage right-shift / parallel-load register with snapshot stream
`timescale 1ns/100ps
module shift4_right_left
   import shift4_pkg::*;
#(
   parameter int FIFO_DEPTH = SNAP_DEPTH
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       mode_sel,
   input  wire logic       shift_clk,
   input  wire logic       load_clk,
   input  wire logic       serial_in,
   input  wire logic [3:0] par_in,
   output logic            stage_one_out,
   output logic            stage_two_out,
   output logic            stage_three_out,
   output logic            stage_four_out,
   output logic            snap_valid,
   output logic [3:0]      snap_data,
   input  wire logic       snap_ready,
   output logic            snap_room,
   output logic            snap_drop
);
   logic [PIN_W-1:0]  meta_q;
   logic [PIN_W-1:0]  sync_q;
   logic [PIN_W-1:0]  prev_q;
   logic [STAGES-1:0] stage_q;
   logic [STAGES-1:0] stage_d;
   logic              load_fall;
   logic              shift_fall;
   logic              load_ev;
   logic              shift_ev;
   logic              out_valid_q;
   logic [STAGES-1:0] out_data_q;
   logic              room_q;
   logic              drop_q;
   logic              take;

   snap_stream_if #(.WIDTH(STAGES)) push_if ();
   snap_stream_if #(.WIDTH(STAGES)) pop_if ();

   // every pin is asynchronous to sys_clk: two flops before any logic looks at it
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q <= PIN_RST;
         sync_q <= PIN_RST;
      end else begin
         meta_q <= {mode_sel, shift_clk, load_clk, serial_in, par_in};
         sync_q <= meta_q;
      end
   end

   // previous synchronised level for edge detection; reset low so release makes no edge
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         prev_q <= PIN_RST;
      end else begin
         prev_q <= sync_q;
      end
   end

   // falling edges only; a clock held high or rising does nothing
   assign load_fall  = prev_q[LOAD_CLK_BIT] & ~sync_q[LOAD_CLK_BIT];
   assign shift_fall = prev_q[SHIFT_CLK_BIT] & ~sync_q[SHIFT_CLK_BIT];
   // mode picks which clock counts; mode edges themselves are no event
   assign load_ev    = sync_q[MODE_BIT] & load_fall;
   assign shift_ev   = ~sync_q[MODE_BIT] & shift_fall;

   // next stage value: load broadside, or shift toward stage four
   always_comb begin
      stage_d = stage_q;
      if (load_ev) begin
         stage_d = sync_q[PAR_LSB +: STAGES];
      end else if (shift_ev) begin
         stage_d = {stage_q[STAGES-2:0], sync_q[SER_BIT]};
      end
   end

   // the part has no clear; the sync reset only gives simulation a known start
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stage_q <= STAGE_RST;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign stage_one_out   = stage_q[0];
   assign stage_two_out   = stage_q[1];
   assign stage_three_out = stage_q[2];
   assign stage_four_out  = stage_q[3];

   // each update offers its new word to the buffer; the register never waits on it
   assign push_if.valid = load_ev | shift_ev;
   assign push_if.data  = stage_d;

   snap_fifo #(
      .WIDTH (STAGES),
      .DEPTH (FIFO_DEPTH)
   ) u_snap_fifo (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .push    (push_if),
      .pop     (pop_if)
   );

   // output register so the stream ports come from flops; refill when empty or taken
   assign take         = ~out_valid_q | snap_ready;
   assign pop_if.ready = take;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_valid_q <= 1'b0;
      end else if (take) begin
         out_valid_q <= pop_if.valid;
      end
   end

   // data only moves with a real word, so an empty buffer never shows unwritten storage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_data_q <= STAGE_RST;
      end else if (take && pop_if.valid) begin
         out_data_q <= pop_if.data;
      end
   end

   // room and drop: a pin edge cannot be held off, so a full buffer loses the snapshot
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         room_q <= 1'b0;
         drop_q <= 1'b0;
      end else begin
         room_q <= push_if.ready;
         drop_q <= push_if.valid & ~push_if.ready;
      end
   end

   assign snap_valid = out_valid_q;
   assign snap_data  = out_data_q;
   assign snap_room  = room_q;
   assign snap_drop  = drop_q;

   // checks on the stage logic and the drop flag
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence seq_load_edge;
      sync_q[MODE_BIT] && load_fall;
   endsequence

   sequence seq_shift_edge;
      !sync_q[MODE_BIT] && shift_fall;
   endsequence

   sequence seq_mode_only;
      $changed(sync_q[MODE_BIT]) && !load_fall && !shift_fall;
   endsequence

   sequence seq_snap_stall;
      snap_valid && !snap_ready;
   endsequence

   a_load_copies_par: assert property (seq_load_edge |=> stage_q == $past(sync_q[PAR_LSB +: STAGES]))
      else $error("load edge did not copy parallel inputs");

   a_shift_moves_right: assert property (seq_shift_edge |=>
      stage_q == {$past(stage_q[2:0]), $past(sync_q[SER_BIT])})
      else $error("shift edge did not move stages");

   a_hold_without_edge: assert property (!load_fall && !shift_fall |=> $stable(stage_q))
      else $error("stages changed with no falling clock edge");

   a_mode_change_holds: assert property (seq_mode_only |=> $stable(stage_q))
      else $error("mode change alone altered the stages");

   a_load_ignores_shift: assert property (sync_q[MODE_BIT] && shift_fall && !load_fall |=> $stable(stage_q))
      else $error("load mode reacted to shift clock");

   a_shift_ignores_load: assert property (!sync_q[MODE_BIT] && load_fall && !shift_fall |=> $stable(stage_q))
      else $error("shift mode reacted to load clock");

   // checker helpers: shifts since the last load, saturating at four, and the last four serial bits shifted in
   logic [2:0]        shift_run_q;
   logic [STAGES-1:0] ser_hist_q;

   // a load restarts the run; after four shifts no loaded bit can remain
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shift_run_q <= 3'h0;
      end else if (load_ev) begin
         shift_run_q <= 3'h0;
      end else if (shift_ev && (shift_run_q != 3'(STAGES))) begin
         shift_run_q <= shift_run_q + 3'h1;
      end
   end

   // serial history kept apart from the stages, so a wrong shift path shows up
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ser_hist_q <= STAGE_RST;
      end else if (shift_ev) begin
         ser_hist_q <= {ser_hist_q[STAGES-2:0], sync_q[SER_BIT]};
      end
   end

   a_four_shifts_flush: assert property (shift_run_q == 3'(STAGES) |-> stage_q == ser_hist_q)
      else $error("stages not equal to last four serial bits after four shifts");

   a_reset_stage_value: assert property (disable iff (1'b0) !rst_n |=> stage_q == STAGE_RST)
      else $error("stages not at start value after reset");

   a_drop_when_full: assert property (push_if.valid && !push_if.ready |=> snap_drop)
      else $error("lost snapshot not flagged");

   // checks on the snapshot stream side
   a_snap_holds_stall: assert property (seq_snap_stall |=> snap_valid && $stable(snap_data))
      else $error("stalled snapshot word moved");

   a_snap_empty_idle: assert property (snap_ready && !pop_if.valid |=> !snap_valid)
      else $error("snapshot valid with empty buffer");

   a_snap_refills: assert property (snap_valid && snap_ready && pop_if.valid |=>
      snap_valid && snap_data == $past(pop_if.data))
      else $error("taken word not replaced by next buffered word");
endmodule : shift4_right_left

// *** verilog/snap_fifo.sv ***
// synchronous fifo for stage snapshots, width and depth set by parameters
`timescale 1ns/100ps
module snap_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 32
) (
   input  wire logic   sys_clk,
   input  wire logic   rst_n,
   snap_stream_if.snk  push,
   snap_stream_if.src  pop
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             do_push;
   logic             do_pop;

   // honest flags straight from the occupancy count
   assign push.ready = (count_q != (AW+1)'(DEPTH));
   assign pop.valid  = (count_q != '0);
   assign pop.data   = mem[rd_ptr_q];
   assign do_push    = push.valid & push.ready;
   assign do_pop     = pop.valid & pop.ready;

   // storage has no reset; only pointers and count need a defined value
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem[wr_ptr_q] <= push.data;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
      end
   end

   // occupancy, push and pop in one cycle cancel
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (do_push && !do_pop) begin
         count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
         count_q <= count_q - 1'b1;
      end
   end
endmodule : snap_fifo

// *** verilog/snap_stream_if.sv ***
// valid/ready word stream between the shift register core and its snapshot buffer
`timescale 1ns/100ps
interface snap_stream_if #(
   parameter int WIDTH = 4
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : snap_stream_if
